// ==== rtl/csc_pkg.sv ====
// Constants, register map and state types of the system clock select block.
// Assumes one 10 MHz master clock that stands for the four-times multiplied crystal clock.
// Summary of operation
// [R1] Reset selects divide-by-4: crystal clock passes straight, four clocks per machine cycle.
// [R2] A new divide selection takes effect at the end of the running machine cycle.
// [R3] The selected system clock tick drives all clocked functions, timers and baud rates.
// [R4] Away from divide-by-4 only a write of the divide-by-4 code is accepted.
// [R5] From divide-by-4 the divide-by-1024 code may be written.
// [R6] Writes toward a disallowed selection are ignored and the old selection stays.
// [R7] The multiplier factor bit changes only while the multiplier is disabled.
// [R8] The multiplier enable changes only at divide-by-4 with ring mode off.
// [R9] Clearing the multiplier enable clears clock ready and restarts stabilization.
// [R10] While stabilizing, ready stays low and the multiplier cannot be selected.
// [R11] Hardware sets ready after stabilization; software cannot set it.
// [R12] Software waits for ready, sets factor, enables multiplier, then selects it.
// [R13] The oscillator-fail detector is enabled by a timed-access write of one.
// [R14] An enabled detector holds the processor in reset while the oscillator is slow.
// [R15] The fail flag is set by hardware, cleared by power-up reset or writing zero.
// [R16] The detector keeps running whatever the processor power state.
// [R17] Power-management mode gives input divided by 256, 1024 clocks per machine cycle.
// [R18] Only a software write selects power-management mode.
// [R19] Select codes: 00 multiplier, 01 reserved, 10 divide-by-4, 11 divide-by-1024.
// [R20] Factor bit one multiplies by four, zero by two.
// [R21] The machine cycle generator always divides the system clock by four.
// [R22] Stabilization time and fail threshold are design parameters.
// [R23] Source changes happen on common clock boundaries so no short pulse appears.
package csc_pkg;
  localparam logic [3:0] ADDR_CLK_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PWR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_CLK_STAT = 4'h8;
  localparam int SEL_LO = 6;
  localparam int MEN_BIT = 4;
  localparam int MFAC_BIT = 3;
  localparam int RDY_BIT = 3;
  localparam int RING_BIT = 2;
  localparam int OFE_BIT = 4;
  localparam int OFF_BIT = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_HZ = 10_000_000;
  localparam int PMM_CNT_W = 10;
  localparam int STAB_TIME_US = 100;
  localparam int STAB_CYC = (STAB_TIME_US * CLK_HZ) / 1_000_000;
  localparam int FAIL_TIME_NS = 3200;
  localparam int FAIL_CYC = (FAIL_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
  typedef enum logic [1:0] {
    CSC_SEL_MULT = 2'h0,
    CSC_SEL_RSVD = 2'h1,
    CSC_SEL_DIV4 = 2'h2,
    CSC_SEL_PMM = 2'h3
  } csc_sel_t;
  typedef enum logic [1:0] {
    CSC_STB_RUN = 2'h1,
    CSC_STB_READY = 2'h2
  } csc_stb_t;
endpackage

// ==== rtl/csc_reg_if.sv ====
// Register access carrier between the bus slave and the clock control core.
// Assumes both ends run on the same master clock.
`timescale 1ns/100ps
interface csc_reg_if;
  logic wr;
  logic [3:0] waddr;
  logic [31:0] wdata;
  logic werr;
  logic [3:0] raddr;
  logic [31:0] rdata;
  logic rerr;
  modport bus (output wr, output waddr, output wdata, output raddr, input werr, input rdata, input rerr);
  modport core (input wr, input waddr, input wdata, input raddr, output werr, output rdata, output rerr);
endinterface

// ==== rtl/csc_axi_slave.sv ====
// AXI4-Lite slave that turns bus transfers into single-cycle register strobes.
// Assumes the core answers read data and errors combinationally from the address.
`timescale 1ns/100ps
module csc_axi_slave #(
  parameter int ADDR_W = 4
) (
  input wire logic mclk,
  input wire logic rst_ni,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  csc_reg_if.bus rif
);
  initial begin
    if (ADDR_W < 4) $error("csc_axi_slave: ADDR_W must be at least 4");
  end
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic w_hs, r_hs;

  // Address and data are taken together, so neither channel can run ahead of the other.
  assign w_hs = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign r_hs = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = w_hs;
  assign s_axi_wready = w_hs;
  assign s_axi_arready = !rvalid_q;
  assign rif.wr = w_hs && s_axi_wstrb[0];
  assign rif.waddr = s_axi_awaddr[3:0];
  assign rif.wdata = s_axi_wdata;
  assign rif.raddr = s_axi_araddr[3:0];
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  always_comb begin
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (w_hs) begin
      bvalid_d = 1'b1;
      bresp_d = rif.werr ? csc_pkg::RESP_SLVERR : csc_pkg::RESP_OKAY;
    end
    if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
    if (r_hs) begin
      rvalid_d = 1'b1;
      rresp_d = rif.rerr ? csc_pkg::RESP_SLVERR : csc_pkg::RESP_OKAY;
      rdata_d = rif.rdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_ni) begin
    if (!rst_ni) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end
endmodule // csc_axi_slave

// ==== rtl/csc_osc_fail.sv ====
// Oscillator-fail detector: flags a crystal input whose edges come too far apart.
// Assumes osc_in is asynchronous to mclk and much slower than it.
`timescale 1ns/100ps
module csc_osc_fail #(
  parameter int FAIL_CYC = csc_pkg::FAIL_CYC
) (
  input wire logic mclk,
  input wire logic rst_ni,
  input wire logic osc_in,
  output logic slow
);
  initial begin
    if (FAIL_CYC < 2 || FAIL_CYC > 65535) $error("csc_osc_fail: FAIL_CYC out of range");
  end
  logic meta_q, sync_q, prev_q, slow_q, slow_d;
  logic [15:0] gap_q, gap_d;

  // The detector has no power-state input, so it keeps watching in every mode.
  always_comb begin
    gap_d = gap_q;
    slow_d = slow_q;
    if (sync_q && !prev_q) begin
      gap_d = 16'h0000;
      slow_d = 1'b0;
    end else if (gap_q == 16'(FAIL_CYC - 1)) begin
      slow_d = 1'b1; // see [R16]
    end else begin
      gap_d = gap_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_ni) begin
    if (!rst_ni) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      gap_q <= 16'h0000;
      slow_q <= 1'b0;
    end else begin
      meta_q <= osc_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      gap_q <= gap_d;
      slow_q <= slow_d;
    end
  end
  assign slow = slow_q;
endmodule // csc_osc_fail

// ==== rtl/csc_top.sv ====
// System clock select core: divide selection, multiplier handshake, machine cycle ticks.
// Assumes mclk is the four-times crystal clock; all clocks are made as one-cycle ticks.
`timescale 1ns/100ps
module csc_top #(
  parameter int ADDR_W = 4,
  parameter int STAB_CYC = csc_pkg::STAB_CYC,
  parameter int FAIL_CYC = csc_pkg::FAIL_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic osc_in,
  input wire logic ring_mode_bit,
  input wire logic ta_open,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sys_tick,
  output logic [1:0] mc_phase,
  output logic mc_tick,
  output logic mult_on,
  output logic power_mgmt_mode,
  output logic cpu_rst_n
);
  initial begin
    if (STAB_CYC < 2 || STAB_CYC > 65535) $error("csc_top: STAB_CYC out of range");
  end

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  logic rst_meta_q, rst_ni, ring_meta_q, ring_s_q;
  csc_pkg::csc_sel_t sel_q, sel_d, act_q, act_d;
  logic men_q, men_d, mfac_q, mfac_d, ofe_q, ofe_d, off_q, off_d;
  csc_pkg::csc_stb_t st_q, st_d;
  logic [15:0] stab_q, stab_d;
  logic [csc_pkg::PMM_CNT_W-1:0] cnt_q;
  logic [1:0] phase_q, phase_d;
  logic tick_q, tick_d, mc_q, mc_d, crst_q, slow, rdy, restart, wr_ctrl, wr_pwr;
  csc_pkg::csc_sel_t new_sel;

  // Reset is released through two flip-flops.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_ni <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_ni <= rst_meta_q;
    end
  end

  csc_reg_if rif ();

  csc_axi_slave #(.ADDR_W(ADDR_W)) u_axi (
    .mclk(mclk),
    .rst_ni(rst_ni),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif.bus)
  );

  csc_osc_fail #(.FAIL_CYC(FAIL_CYC)) u_ofd (
    .mclk(mclk),
    .rst_ni(rst_ni),
    .osc_in(osc_in),
    .slow(slow)
  );

  assign rdy = (st_q == csc_pkg::CSC_STB_READY);
  assign wr_ctrl = rif.wr && hit(rif.waddr, csc_pkg::ADDR_CLK_CTRL);
  assign wr_pwr = rif.wr && hit(rif.waddr, csc_pkg::ADDR_PWR_CTRL);
  assign new_sel = csc_pkg::csc_sel_t'(rif.wdata[csc_pkg::SEL_LO +: 2]);

  // Register writes; decisions use the values held before the write.
  always_comb begin
    sel_d = sel_q;
    men_d = men_q;
    mfac_d = mfac_q;
    ofe_d = ofe_q;
    off_d = off_q;
    if (wr_ctrl) begin
      if (sel_q == csc_pkg::CSC_SEL_DIV4) begin
        if (new_sel == csc_pkg::CSC_SEL_PMM) sel_d = new_sel; // see [R5] see [R18]
        else if (new_sel == csc_pkg::CSC_SEL_MULT && rdy) sel_d = new_sel; // see [R10] see [R12]
      end else if (new_sel == csc_pkg::CSC_SEL_DIV4) begin
        sel_d = new_sel; // see [R4] see [R6]
      end
      if (sel_q == csc_pkg::CSC_SEL_DIV4 && !ring_s_q) men_d = rif.wdata[csc_pkg::MEN_BIT]; // see [R8]
      if (!men_q) mfac_d = rif.wdata[csc_pkg::MFAC_BIT]; // see [R7]
    end
    if (wr_pwr) begin
      if (ta_open) ofe_d = rif.wdata[csc_pkg::OFE_BIT]; // see [R13]
      if (!rif.wdata[csc_pkg::OFF_BIT]) off_d = 1'b0;
    end
    if (ofe_q && slow) off_d = 1'b1; // see [R15]
  end

  // Stabilization timer for the multiplier; clearing the enable restarts it.
  assign restart = men_q && !men_d; // see [R9]
  always_comb begin
    st_d = st_q;
    stab_d = stab_q;
    case (st_q)
      csc_pkg::CSC_STB_RUN: begin
        if (stab_q == 16'(STAB_CYC - 1)) st_d = csc_pkg::CSC_STB_READY; // see [R11] see [R22]
        else stab_d = stab_q + 16'h0001;
      end
      csc_pkg::CSC_STB_READY: st_d = csc_pkg::CSC_STB_READY;
      default: st_d = csc_pkg::CSC_STB_RUN;
    endcase
    if (restart) begin
      st_d = csc_pkg::CSC_STB_RUN;
      stab_d = 16'h0000;
    end
  end

  // Clock ticks. The free counter aligns every source so a switch never shortens a period.
  always_comb begin
    tick_d = 1'b0;
    case (act_q)
      csc_pkg::CSC_SEL_MULT: tick_d = mfac_q ? 1'b1 : cnt_q[0]; // see [R20]
      csc_pkg::CSC_SEL_PMM: tick_d = &cnt_q; // see [R17]
      default: tick_d = &cnt_q[1:0]; // see [R1]
    endcase
    phase_d = phase_q;
    mc_d = 1'b0;
    act_d = act_q;
    if (tick_q) begin
      phase_d = phase_q + 2'h1; // see [R21] see [R3]
      if (phase_q == 2'h3) begin
        mc_d = 1'b1;
        act_d = sel_q; // see [R2] see [R23]
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_ni) begin
    if (!rst_ni) begin
      ring_meta_q <= 1'b0;
      ring_s_q <= 1'b0;
      sel_q <= csc_pkg::CSC_SEL_DIV4;
      act_q <= csc_pkg::CSC_SEL_DIV4;
      men_q <= 1'b0;
      mfac_q <= 1'b0;
      ofe_q <= 1'b0;
      off_q <= 1'b0;
      st_q <= csc_pkg::CSC_STB_RUN;
      stab_q <= 16'h0000;
      cnt_q <= '0;
      phase_q <= 2'h0;
      tick_q <= 1'b0;
      mc_q <= 1'b0;
      crst_q <= 1'b0;
    end else begin
      ring_meta_q <= ring_mode_bit;
      ring_s_q <= ring_meta_q;
      sel_q <= sel_d;
      act_q <= act_d;
      men_q <= men_d;
      mfac_q <= mfac_d;
      ofe_q <= ofe_d;
      off_q <= off_d;
      st_q <= st_d;
      stab_q <= stab_d;
      cnt_q <= cnt_q + 1'b1;
      phase_q <= phase_d;
      tick_q <= tick_d;
      mc_q <= mc_d;
      crst_q <= !(ofe_q && slow); // see [R14]
    end
  end

  // Register reads.
  always_comb begin
    rif.rdata = 32'h0000_0000;
    rif.rerr = 1'b0;
    if (hit(rif.raddr, csc_pkg::ADDR_CLK_CTRL)) begin
      rif.rdata[csc_pkg::SEL_LO +: 2] = sel_q; // see [R19]
      rif.rdata[csc_pkg::MEN_BIT] = men_q;
      rif.rdata[csc_pkg::MFAC_BIT] = mfac_q;
    end else if (hit(rif.raddr, csc_pkg::ADDR_PWR_CTRL)) begin
      rif.rdata[csc_pkg::OFE_BIT] = ofe_q;
      rif.rdata[csc_pkg::OFF_BIT] = off_q;
    end else if (hit(rif.raddr, csc_pkg::ADDR_CLK_STAT)) begin
      rif.rdata[csc_pkg::RDY_BIT] = rdy;
      rif.rdata[csc_pkg::RING_BIT] = ring_s_q;
    end else begin
      rif.rerr = 1'b1;
    end
  end
  assign rif.werr = !(hit(rif.waddr, csc_pkg::ADDR_CLK_CTRL) || hit(rif.waddr, csc_pkg::ADDR_PWR_CTRL)
                      || hit(rif.waddr, csc_pkg::ADDR_CLK_STAT));

  assign sys_tick = tick_q;
  assign mc_phase = phase_q;
  assign mc_tick = mc_q;
  assign mult_on = men_q;
  assign power_mgmt_mode = (act_q == csc_pkg::CSC_SEL_PMM);
  assign cpu_rst_n = crst_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_ni);

  chk_reset_div4: assert property ($rose(rst_ni) |-> act_q == csc_pkg::CSC_SEL_DIV4) // see [R1]
    else $error("selection not divide-by-4 after reset");
  chk_switch_at_mc: assert property (act_q != $past(act_q) |-> $past(mc_d)) // see [R2]
    else $error("selection changed off a machine cycle end");
  chk_div4_tick: assert property (tick_q && $past(act_q) == csc_pkg::CSC_SEL_DIV4 |-> $past(cnt_q[1:0]) == 2'h3) // see [R3]
    else $error("divide-by-4 tick misplaced");
  chk_away_only_div4: assert property (wr_ctrl && sel_q != csc_pkg::CSC_SEL_DIV4
    |=> sel_q == csc_pkg::CSC_SEL_DIV4 || $stable(sel_q)) // see [R4]
    else $error("illegal leave from non divide-by-4 selection");
  chk_no_reserved: assert property (sel_q != csc_pkg::CSC_SEL_RSVD) // see [R6]
    else $error("reserved selection stored");
  chk_factor_lock: assert property ($past(men_q) |-> $stable(mfac_q)) // see [R7]
    else $error("factor changed while multiplier on");
  chk_enable_lock: assert property ($changed(men_q) |-> $past(sel_q) == csc_pkg::CSC_SEL_DIV4 && !$past(ring_s_q)) // see [R8]
    else $error("multiplier enable changed when locked");
  chk_ready_clear: assert property ($fell(men_q) |-> !rdy ##1 !rdy) // see [R9]
    else $error("ready not cleared on multiplier disable");
  chk_mult_gate: assert property ($changed(sel_q) && sel_q == csc_pkg::CSC_SEL_MULT |-> $past(rdy)) // see [R10]
    else $error("multiplier selected before ready");
  chk_ready_set: assert property (st_q == csc_pkg::CSC_STB_RUN && stab_q == 16'(STAB_CYC - 1) && !restart |=> rdy) // see [R11]
    else $error("ready not set after stabilization");
  chk_fail_reset: assert property (ofe_q && slow |=> !cpu_rst_n && off_q) // see [R14]
    else $error("oscillator failure did not reset");
  chk_flag_clear: assert property ($fell(off_q) |-> $past(wr_pwr) && !$past(ofe_q && slow)) // see [R15]
    else $error("fail flag cleared without write");
  chk_pmm_by_write: assert property ($changed(sel_q) |-> $past(wr_ctrl)) // see [R18]
    else $error("selection changed without a write");
  chk_mc_four: assert property (tick_q && phase_q == 2'h3 |=> mc_tick && phase_q == 2'h0) // see [R21]
    else $error("machine cycle not four ticks");
endmodule // csc_top

// ==== test/csc_top_tb_top.sv ====
// Self-checking bench for the system clock select block: register rows, clock rates, oscillator fail.
// Assumes the design files under rtl/ are compiled first; drives every port of csc_top itself.
`timescale 1ns/100ps
module csc_top_tb_top;
  typedef struct {logic wr; logic ta; logic [3:0] addr; logic [31:0] data; logic [31:0] exp; logic [1:0] resp;} csc_row_t;
  localparam logic [1:0] OK = csc_pkg::RESP_OKAY;
  localparam logic [1:0] ER = csc_pkg::RESP_SLVERR;
  logic mclk, rst_n, osc_in, ring_mode_bit, ta_open, osc_run;
  logic [3:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp, resp;
  logic sys_tick, mc_tick, mult_on, power_mgmt_mode, cpu_rst_n;
  logic [1:0] mc_phase;
  int error_cnt, tests_run;
  csc_row_t rows [25];
  csc_top #(.ADDR_W(4), .STAB_CYC(16), .FAIL_CYC(8)) i_csc_top (.mclk(mclk), .rst_n(rst_n), .osc_in(osc_in),
    .ring_mode_bit(ring_mode_bit), .ta_open(ta_open), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sys_tick(sys_tick),
    .mc_phase(mc_phase), .mc_tick(mc_tick), .mult_on(mult_on), .power_mgmt_mode(power_mgmt_mode),
    .cpu_rst_n(cpu_rst_n));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // The crystal stand-in toggles every master clock while running, well inside the fail limit.
  always @(posedge mclk) begin
    if (osc_run) osc_in <= ~osc_in;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic hang(input string what);
    error_cnt++;
    $display("unexpected at %0t: no answer for %s", $time, what);
    give_verdict();
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100 && !(awready === 1'b1 && wready === 1'b1); n++) @(negedge mclk);
    if (n == 100) hang("write address");
    @(posedge mclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    for (n = 0; n < 100 && bvalid !== 1'b1; n++) @(negedge mclk);
    if (n == 100) hang("write response");
    r = bresp;
    @(posedge mclk);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100 && arready !== 1'b1; n++) @(negedge mclk);
    if (n == 100) hang("read address");
    @(posedge mclk);
    arvalid <= 1'b0;
    for (n = 0; n < 100 && rvalid !== 1'b1; n++) @(negedge mclk);
    if (n == 100) hang("read data");
    d = rdata;
    r = rresp;
    @(posedge mclk);
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    axi_wr(a, d, resp);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    axi_rd(a, got, resp);
    check(got, e, "read data");
  endtask
  // Waits for a chosen output to reach a level: 0 selects the processor reset, 1 the low-power flag.
  task automatic wait_lvl(input int which, input logic lvl, input int bound);
    int n;
    for (n = 0; n < bound && (which == 0 ? cpu_rst_n : power_mgmt_mode) !== lvl; n++) @(negedge mclk);
    if (n == bound) hang("level change");
  endtask
  // Counts master clocks between two successive tick pulses.
  task automatic tick_gap(input bit mc, output logic [31:0] g);
    int n;
    for (n = 0; n < 5000 && (mc ? mc_tick : sys_tick) !== 1'b1; n++) @(negedge mclk);
    if (n == 5000) hang("first tick");
    g = 0;
    do begin
      @(negedge mclk);
      g++;
    end while ((mc ? mc_tick : sys_tick) !== 1'b1 && g < 5000);
  endtask
  initial begin
    rows = '{'{0,0,4'h0,0,32'h80,OK}, '{1,0,4'h0,32'h40,0,OK}, '{0,0,4'h0,0,32'h80,OK},
      '{1,0,4'h0,32'h88,0,OK}, '{0,0,4'h0,0,32'h88,OK}, '{1,0,4'h0,32'h98,0,OK}, '{0,0,4'h0,0,32'h98,OK},
      '{1,0,4'h0,32'h90,0,OK}, '{0,0,4'h0,0,32'h98,OK}, '{1,0,4'h0,32'h18,0,OK}, '{0,0,4'h0,0,32'h18,OK},
      '{1,0,4'h0,32'hd8,0,OK}, '{0,0,4'h0,0,32'h18,OK}, '{1,0,4'h0,32'h98,0,OK}, '{1,0,4'h0,32'h88,0,OK},
      '{1,0,4'h8,32'h08,0,OK}, '{0,0,4'h8,0,32'h00,OK}, '{1,0,4'h0,32'h08,0,OK}, '{0,0,4'h0,0,32'h88,OK},
      '{1,0,4'hc,32'h1,0,ER}, '{0,0,4'hc,0,32'h0,ER}, '{1,0,4'h4,32'h10,0,OK}, '{0,0,4'h4,0,32'h00,OK},
      '{1,1,4'h4,32'h10,0,OK}, '{0,1,4'h4,0,32'h10,OK}};
    error_cnt = 0;
    tests_run = 0;
    rst_n = 1'b0;
    osc_in = 1'b0;
    osc_run = 1'b1;
    ring_mode_bit = 1'b0;
    ta_open = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (40) @(posedge mclk);
    check(cpu_rst_n, 1'b1, "processor reset released");
    check(power_mgmt_mode, 1'b0, "low power after reset");
    foreach (rows[i]) begin
      ta_open <= rows[i].ta;
      if (rows[i].wr) axi_wr(rows[i].addr, rows[i].data, resp);
      else begin
        axi_rd(rows[i].addr, got, resp);
        check(got, rows[i].exp, "row read");
      end
      check(resp, rows[i].resp, "row response");
    end
    repeat (30) @(posedge mclk);
    rd_chk(4'h8, 32'h08);
    ring_mode_bit <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_chk(4'h8, 32'h0c);
    wr(4'h0, 32'h98);
    rd_chk(4'h0, 32'h88);
    ring_mode_bit <= 1'b0;
    repeat (4) @(posedge mclk);
    tick_gap(0, got);
    check(got, 4, "divide-by-4 tick gap");
    tick_gap(1, got);
    check(got, 16, "machine cycle gap");
    check(mc_phase, 2'h0, "phase after machine cycle");
    wr(4'h0, 32'h98);
    wr(4'h0, 32'h18);
    check(mult_on, 1'b1, "multiplier on");
    repeat (20) @(posedge mclk);
    tick_gap(0, got);
    check(got, 1, "times four tick gap");
    tick_gap(1, got);
    check(got, 4, "multiplied machine cycle");
    wr(4'h0, 32'h98);
    wr(4'h0, 32'h88);
    wr(4'h0, 32'h80);
    repeat (30) @(posedge mclk);
    wr(4'h0, 32'h90);
    wr(4'h0, 32'h10);
    repeat (20) @(posedge mclk);
    tick_gap(0, got);
    check(got, 2, "times two tick gap");
    wr(4'h0, 32'h90);
    wr(4'h0, 32'hd0);
    wait_lvl(1, 1'b1, 100);
    tick_gap(0, got);
    check(got, 1024, "low power tick gap");
    wr(4'h0, 32'h50);
    rd_chk(4'h0, 32'hd0);
    wr(4'h0, 32'h90);
    check(power_mgmt_mode, 1'b1, "change waits for cycle end");
    wait_lvl(1, 1'b0, 4200);
    tick_gap(0, got);
    check(got, 4, "back to divide-by-4");
    osc_run <= 1'b0;
    wait_lvl(0, 1'b0, 40);
    repeat (10) @(posedge mclk);
    check(cpu_rst_n, 1'b0, "reset held while slow");
    osc_run <= 1'b1;
    wait_lvl(0, 1'b1, 40);
    rd_chk(4'h4, 32'h30);
    wr(4'h4, 32'h10);
    rd_chk(4'h4, 32'h10);
    give_verdict();
  end
endmodule // csc_top_tb_top
